/* File: core/sag_detect_and_event_irq.sv */
`timescale 1ns/1ns
module sag_detect_and_event_irq
   import sag_event_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic srst,
   // serial port
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   output logic dout,
   output logic doutEn,
   // event pins
   output logic irqN,
   output logic dipAlarmN,
   output logic zeroCross,
   // analog front end
   input wire logic sampleValid,
   input wire logic [19:0] lpfSample,
   input wire logic supplyLow,
   input wire logic [7:0] tempCode,
   output logic tempSelect,
   output logic energyEnable
);

   // serial port side
   logic cmdDone, cmdRead, wrStrobe, xferDone, statusCmd;
   logic [5:0] cmdAddr;
   logic [15:0] rdData, wrData;
   // registers
   logic [7:0] flags, mode, mask, dipThreshold, dipHalfcycles, temp;
   logic [11:0] zxTimeout;
   // supply, crossing and dip state
   logic [1:0] supS;
   logic supPrev, active, recover, sv, pos, sgnPrev, zxPulse;
   logic [19:0] absS;
   logic [7:0] magByte, hcCnt;
   logic below, aboveNow, peakHi, dipEvent, alarm, alarmTo;
   // timeout, temperature and interrupt
   logic [6:0] div;
   logic [11:0] zxCnt;
   logic tick, toHit, tempLaunch, tempDone, pend, irqHold;
   temp_state_t tSt;
   logic [4:0] tCnt;
   logic [7:0] evts;

   // ***************************************************
   // serial port
   // ***************************************************
   serial_port_slave u_port (
      .clk_sys(clk_sys),
      .srst(srst),
      .sclk(sclk),
      .csN(csN),
      .din(din),
      .dout(dout),
      .doutEn(doutEn),
      .cmdDone(cmdDone),
      .cmdRead(cmdRead),
      .cmdAddr(cmdAddr),
      .rdData(rdData),
      .wrStrobe(wrStrobe),
      .wrData(wrData),
      .xferDone(xferDone)
   );

   // read mux; the slave captures it in the command-end cycle
   always_comb begin
      rdData = 16'h0000;
      case (cmdAddr)
         ADDR_FLAGS, ADDR_FLAGS_RC: rdData = {8'h00, flags};
         ADDR_MODE: rdData = {8'h00, mode};
         ADDR_MASK: rdData = {8'h00, mask};
         ADDR_ZXTO: rdData = {4'h0, zxTimeout};
         ADDR_TEMP: rdData = {8'h00, temp};
         ADDR_DIPCYC: rdData = {8'h00, dipHalfcycles};
         ADDR_DIPLVL: rdData = {8'h00, dipThreshold};
         default: rdData = 16'h0000;
      endcase
   end

   assign statusCmd = cmdDone && cmdRead && cmdAddr == ADDR_FLAGS_RC;

   // ***************************************************
   // software settings
   // ***************************************************
   // a mode write in the launch cycle wins over the self clear;
   // writes to other registers must not keep the start bit alive
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode <= MODE_RST;
         mask <= MASK_RST;
         dipThreshold <= DIPLVL_RST;
         dipHalfcycles <= DIPCYC_RST;
         zxTimeout <= ZXTO_RST;
      end else begin
         if (tempLaunch) begin
            mode[MODE_TEMP] <= 1'b0;
         end
         if (wrStrobe) begin
            case (cmdAddr)
               ADDR_MODE: mode <= wrData[7:0];
               ADDR_MASK: mask <= wrData[7:0] & MASK_IMPL;
               ADDR_ZXTO: zxTimeout <= wrData[11:0];
               ADDR_DIPCYC: dipHalfcycles <= wrData[7:0];
               ADDR_DIPLVL: dipThreshold <= wrData[7:0];
               default: mask <= mask;
            endcase
         end
      end
   end

   // ***************************************************
   // supply monitor
   // ***************************************************
   // comparator is asynchronous to clk_sys, so two flops first
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         supS <= 2'h0;
         supPrev <= 1'b0;
         energyEnable <= 1'b0;
      end else begin
         supS <= {supS[0], supplyLow};
         supPrev <= supS[1];
         energyEnable <= !supS[1];
      end
   end

   assign active = !supS[1];
   assign recover = supPrev && !supS[1];

   // ***************************************************
   // zero crossing and magnitude
   // ***************************************************
   assign sv = sampleValid && active;
   assign pos = !lpfSample[SAMPLE_W-1];
   assign zxPulse = sv && (pos != sgnPrev);
   assign absS = lpfSample[SAMPLE_W-1] ? (~lpfSample + 20'h00001)
                                       : lpfSample;
   assign magByte = absS[MAG_LSB+7:MAG_LSB];
   assign below = dipThreshold > magByte;
   assign aboveNow = sv && !below;

   // output follows the sign of each new sample taken while the supply is good
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sgnPrev <= 1'b0;
         zeroCross <= 1'b0;
      end else if (zxPulse) begin
         sgnPrev <= pos;
         zeroCross <= pos;
      end
   end

   // ***************************************************
   // dip detection
   // ***************************************************
   // counts only half cycles whose whole span stayed low
   assign dipEvent = zxPulse && !peakHi && below
      && dipHalfcycles != 8'h00
      && (9'(hcCnt) + 9'h001) == 9'(dipHalfcycles);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hcCnt <= 8'h00;
         peakHi <= 1'b0;
      end else if (zxPulse) begin
         peakHi <= 1'b0;
         if (peakHi || !below) begin
            hcCnt <= 8'h00;
         end else if (hcCnt != 8'hFF) begin
            hcCnt <= hcCnt + 8'h01;
         end
      end else if (aboveNow) begin
         peakHi <= 1'b1;
         hcCnt <= 8'h00;
      end
   end

   // alarm state; a timeout alarm also ends at the next crossing
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         alarm <= 1'b0;
         alarmTo <= 1'b0;
      end else if (dipEvent || toHit) begin
         alarm <= 1'b1;
         alarmTo <= toHit;
      end else if (aboveNow || (zxPulse && alarmTo)) begin
         alarm <= 1'b0;
         alarmTo <= 1'b0;
      end
   end

   // pin held low in reset so the host can watch power state
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dipAlarmN <= 1'b0;
      end else begin
         dipAlarmN <= !(alarm && !mode[MODE_DIP_DIS]);
      end
   end

   // ***************************************************
   // zero crossing timeout
   // ***************************************************
   assign tick = active && div == ZXTO_TICK_LAST;
   assign toHit = tick && !zxPulse && zxCnt == 12'h001;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         div <= 7'h00;
         zxCnt <= ZXTO_RST;
      end else begin
         div <= div + 7'h01;
         if (zxPulse) begin
            zxCnt <= zxTimeout;
         end else if (tick && zxCnt != 12'h000) begin
            zxCnt <= zxCnt - 12'h001;
         end
      end
   end

   // ***************************************************
   // temperature measurement
   // ***************************************************
   assign tempLaunch = zxPulse && mode[MODE_TEMP] && tSt == T_IDLE;

   // converter input is borrowed only for the conversion window
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tSt <= T_IDLE;
         tCnt <= 5'h00;
         tempSelect <= 1'b0;
         temp <= TEMP_RST;
         tempDone <= 1'b0;
      end else begin
         tempDone <= 1'b0;
         case (tSt)
            T_IDLE: if (tempLaunch) begin
               tSt <= T_CONV;
               tCnt <= TEMP_LOAD_CNT;
               tempSelect <= 1'b1;
            end
            T_CONV: if (tCnt == 5'h00) begin
               tSt <= T_IDLE;
               tempSelect <= 1'b0;
               temp <= tempCode;
               tempDone <= 1'b1;
            end else begin
               tCnt <= tCnt - 5'h01;
            end
            default: tSt <= T_IDLE;
         endcase
      end
   end

   // ***************************************************
   // event flags and interrupt
   // ***************************************************
   always_comb begin
      evts = 8'h00;
      evts[FLAG_DIP] = dipEvent || toHit;
      evts[FLAG_TEMP] = tempDone;
      evts[FLAG_SUPPLY] = recover;
   end

   // only bits captured by the read are cleared; new events win
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flags <= FLAGS_RST;
      end else if (statusCmd) begin
         flags <= evts;
      end else begin
         flags <= flags | evts;
      end
   end

   assign pend = |(flags & mask & MASK_IMPL);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irqHold <= 1'b0;
      end else if (statusCmd) begin
         irqHold <= 1'b1;
      end else if (xferDone) begin
         irqHold <= 1'b0;
      end
   end

   // host sees a fresh falling edge for events during the read
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irqN <= 1'b1;
      end else if (statusCmd || (irqHold && !xferDone)) begin
         irqN <= 1'b1;
      end else begin
         irqN <= !pend;
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   hold_start_a: assert property (@(posedge clk_sys) disable iff (srst)
      statusCmd |=> irqN && irqHold)
      else $error("irq not released by status read");

   hold_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
      irqHold && !xferDone |=> irqN)
      else $error("irq low during status data");

   irq_pend_a: assert property (@(posedge clk_sys) disable iff (srst)
      !irqHold && !statusCmd && pend |=> !irqN)
      else $error("enabled flag without irq");

   supply_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
      (flags & ~FLAG_SUPPLY_M) == 8'h00 |=> irqN)
      else $error("supply flag raised irq");

   temp_load_a: assert property (@(posedge clk_sys) disable iff (srst)
      tempLaunch |-> ##24 tempDone ##1 flags[FLAG_TEMP])
      else $error("temperature load late or early");

   temp_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
      tempLaunch && !(wrStrobe && cmdAddr == ADDR_MODE)
      |=> !mode[MODE_TEMP])
      else $error("temperature start bit stuck");

   reset_pin_a: assert property (@(posedge clk_sys)
      srst |=> !dipAlarmN)
      else $error("dip pin high in reset");

   dip_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
      dipEvent || toHit |=> flags[FLAG_DIP])
      else $error("dip flag not set");

   dip_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
      dipEvent && !mode[MODE_DIP_DIS] && !wrStrobe
      |=> ##1 !dipAlarmN)
      else $error("dip pin not asserted");

   dip_release_a: assert property (@(posedge clk_sys) disable iff (srst)
      aboveNow && !toHit && !dipEvent |=> ##1 dipAlarmN)
      else $error("dip pin not released");

   supply_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
      recover |=> flags[FLAG_SUPPLY])
      else $error("recovery not flagged");

   reload_a: assert property (@(posedge clk_sys) disable iff (srst)
      zxPulse |=> zxCnt == $past(zxTimeout))
      else $error("timeout not reloaded");

endmodule : sag_detect_and_event_irq

/* File: include/sag_event_pkg.sv */
// What this block does
// - dip pin low after N low half cycles
// - dip event sets the dip flag
// - dip flag with enable pulls irq low
// - dip pin released once signal reaches threshold
// - threshold compared with shifted magnitude byte
// - below when threshold exceeds byte; zero disables
// - undervoltage makes block inactive, no energy
// - dip pin low during reset
// - supply flag set at power-up and recovery
// - supply flag never raises an interrupt
// - flags set regardless of mask bits
// - irq low while any enabled flag set
// - status read at 05h returns and clears flags
// - irq high from command end to data end
// - events during status read kept, irq re-asserts
// - mode bit 5 starts temperature at crossing
// - temperature loaded 24 cycles after crossing
// - temperature done sets flag, irq if enabled
// - temperature is signed byte, zero near reference
// - timeout counter ticks every 128 cycles
// - crossing output follows voltage polarity changes
// - timeout expiry sets dip flag and pin
package sag_event_pkg;

   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [5:0] ADDR_FLAGS = 6'h04;
   localparam logic [5:0] ADDR_FLAGS_RC = 6'h05;
   localparam logic [5:0] ADDR_MODE = 6'h06;
   localparam logic [5:0] ADDR_MASK = 6'h08;
   localparam logic [5:0] ADDR_ZXTO = 6'h0E;
   localparam logic [5:0] ADDR_TEMP = 6'h11;
   localparam logic [5:0] ADDR_DIPCYC = 6'h13;
   localparam logic [5:0] ADDR_DIPLVL = 6'h14;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int CMD_WRITE_BIT = 7;
   localparam int MODE_DIP_DIS = 3;
   localparam int MODE_TEMP = 5;
   localparam int FLAG_DIP = 1;
   localparam int FLAG_TEMP = 5;
   localparam int FLAG_SUPPLY = 6;
   // bit 6 of the mask has no enable behind it
   localparam logic [7:0] MASK_IMPL = 8'hBF;
   localparam logic [7:0] FLAG_SUPPLY_M = 8'h40;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [7:0] FLAGS_RST = 8'h40;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] DIPLVL_RST = 8'h00;
   localparam logic [7:0] DIPCYC_RST = 8'hFF;
   localparam logic [11:0] ZXTO_RST = 12'hFFF;
   localparam logic [7:0] TEMP_RST = 8'h00;

   // ***************************************************
   // sample format and timing
   // ***************************************************
   localparam int SAMPLE_W = 20;
   // low bit of the top byte of magnitude shifted left once
   localparam int MAG_LSB = 11;
   localparam int ZXTO_TICK_CYC = 128;
   localparam logic [6:0] ZXTO_TICK_LAST = 7'(ZXTO_TICK_CYC - 1);
   localparam int TEMP_DELAY_CYC = 24;
   localparam logic [4:0] TEMP_LOAD_CNT = 5'(TEMP_DELAY_CYC - 2);

   typedef enum logic {PH_CMD, PH_DATA} port_phase_t;
   typedef enum logic {T_IDLE, T_CONV} temp_state_t;

   // registers that need two data bytes on the serial port
   function automatic logic wide_reg(input logic [5:0] a);
      return a == ADDR_ZXTO;
   endfunction : wide_reg

endpackage : sag_event_pkg

/* File: core/serial_port_slave.sv */
`timescale 1ns/1ns
module serial_port_slave
   import sag_event_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic srst,
   // serial pins
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   output logic dout,
   output logic doutEn,
   // register side
   output logic cmdDone,
   output logic cmdRead,
   output logic [5:0] cmdAddr,
   input wire logic [15:0] rdData,
   output logic wrStrobe,
   output logic [15:0] wrData,
   output logic xferDone
);

   logic [1:0] sclkS;
   logic [1:0] csS;
   logic [1:0] dinS;
   logic sclkQ;
   logic sclkFall;
   logic sclkRise;
   logic [4:0] bitCnt;
   logic [15:0] shIn;
   logic [15:0] shOut;
   logic [4:0] lastBit;
   port_phase_t phase;

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   // two flops per pin; edges are found on the second flop only
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sclkS <= 2'h3;
         csS <= 2'h3;
         dinS <= 2'h0;
         sclkQ <= 1'b1;
      end else begin
         sclkS <= {sclkS[0], sclk};
         csS <= {csS[0], csN};
         dinS <= {dinS[0], din};
         sclkQ <= sclkS[1];
      end
   end

   assign sclkFall = sclkQ && !sclkS[1];
   assign sclkRise = !sclkQ && sclkS[1];
   assign lastBit = wide_reg(cmdAddr) ? 5'h0F : 5'h07;

   // ***************************************************
   // bit framing: input sampled on falling clock edges
   // ***************************************************
   always_ff @(posedge clk_sys) begin
      if (srst || csS[1]) begin
         phase <= PH_CMD;
         bitCnt <= 5'h00;
         cmdDone <= 1'b0;
         wrStrobe <= 1'b0;
         xferDone <= 1'b0;
         shIn <= 16'h0000;
         if (srst) begin
            cmdRead <= 1'b0;
            cmdAddr <= 6'h00;
            wrData <= 16'h0000;
         end
      end else begin
         cmdDone <= 1'b0;
         wrStrobe <= 1'b0;
         xferDone <= 1'b0;
         if (sclkFall) begin
            shIn <= {shIn[14:0], dinS[1]};
            bitCnt <= bitCnt + 5'h01;
            case (phase)
               PH_CMD: if (bitCnt == 5'h07) begin
                  // command byte ends on its eighth falling edge
                  phase <= PH_DATA;
                  bitCnt <= 5'h00;
                  cmdRead <= !shIn[CMD_WRITE_BIT-1];
                  cmdAddr <= {shIn[4:0], dinS[1]};
                  cmdDone <= 1'b1;
               end
               PH_DATA: if (bitCnt == lastBit) begin
                  phase <= PH_CMD;
                  bitCnt <= 5'h00;
                  xferDone <= 1'b1;
                  wrStrobe <= !cmdRead;
                  wrData <= {shIn[14:0], dinS[1]};
               end
               default: phase <= PH_CMD;
            endcase
         end
      end
   end

   // ***************************************************
   // read data: loaded at command end, moved on rising edges
   // ***************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shOut <= 16'h0000;
         dout <= 1'b0;
         doutEn <= 1'b0;
      end else begin
         doutEn <= !csS[1] && phase == PH_DATA && cmdRead;
         if (cmdDone) begin
            // single bytes are left aligned so the msb goes first
            shOut <= wide_reg(cmdAddr) ? rdData : {rdData[7:0], 8'h00};
         end else if (sclkRise && phase == PH_DATA && cmdRead) begin
            dout <= shOut[15];
            shOut <= {shOut[14:0], 1'b0};
         end
      end
   end

   cmd_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
      cmdDone |=> !cmdDone) else $error("command strobe too long");

endmodule : serial_port_slave

/* File: bench/host_serial_model.sv */
`timescale 1ns/1ns
module host_serial_model
   import sag_event_pkg::*;
(
   // system
   input wire logic clk_sys,
   // serial pins
   output logic sclk,
   output logic csN,
   output logic din,
   input wire logic dout,
   input wire logic doutEn,
   // interrupt line
   input wire logic irqN,
   output logic irqSeen
);
   logic irqPrev;

   // idle serial clock high, no frame open
   initial begin
      sclk = 1'b1;
      csN = 1'b1;
      din = 1'b0;
      irqPrev = 1'b1;
      irqSeen = 1'b0;
   end

   // service is keyed to falling edges, so a held level never retriggers
   always @(posedge clk_sys) begin
      irqPrev <= irqN;
      if (irqPrev && !irqN) irqSeen <= 1'b1;
   end

   // ***************************************************
   // one frame: command byte then nb data bytes, msb first
   // ***************************************************
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                       input int nb, output logic [15:0] rd);
      logic [23:0] sh;
      sh = (nb == 2) ? {cmd, wd} : {cmd, wd[7:0], 8'h00};
      rd = 16'h0000;
      // edge flag is dropped before the clearing read is started
      if (cmd == {2'b00, ADDR_FLAGS_RC}) irqSeen <= 1'b0;
      @(posedge clk_sys);
      csN <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // 800 ns bit time: data set while high, taken at the fall
      for (int i = 0; i < 8 + 8 * nb; i++) begin
         din <= sh[23 - i];
         repeat (4) @(posedge clk_sys);
         if (i >= 8) rd = {rd[14:0], dout};
         sclk <= 1'b0;
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b1;
      end
      repeat (4) @(posedge clk_sys);
      csN <= 1'b1;
      din <= ~din; // released data line must not keep its last value
      repeat (4) @(posedge clk_sys);
   endtask : xfer
endmodule : host_serial_model

/* File: bench/test_sag_detect_and_event_irq.sv */
`timescale 1ns/1ns
module test_sag_detect_and_event_irq
   import sag_event_pkg::*;
   ;
   logic clk_sys, srst, sclk, csN, din, dout, doutEn, irqN, dipAlarmN;
   logic zeroCross, sampleValid, supplyLow, tempSelect, energyEnable;
   logic irqSeen;
   logic [19:0] lpfSample;
   logic [7:0] tempCode;
   logic [15:0] rv;
   int fails, cmp_count, cyc;

   sag_detect_and_event_irq dut (
      .clk_sys(clk_sys), .srst(srst), .sclk(sclk), .csN(csN), .din(din),
      .dout(dout), .doutEn(doutEn), .irqN(irqN), .dipAlarmN(dipAlarmN),
      .zeroCross(zeroCross), .sampleValid(sampleValid),
      .lpfSample(lpfSample), .supplyLow(supplyLow), .tempCode(tempCode),
      .tempSelect(tempSelect), .energyEnable(energyEnable));

   host_serial_model host (
      .clk_sys(clk_sys), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
      .doutEn(doutEn), .irqN(irqN), .irqSeen(irqSeen));

   // 10 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         report_and_stop();
      end
   end

   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic report_and_stop();
      $display("errors %0d of %0d checks", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk

   task automatic wr(logic [5:0] a, logic [15:0] d);
      host.xfer({2'b10, a}, d, (a == ADDR_ZXTO) ? 2 : 1, rv);
   endtask : wr

   task automatic rd(logic [5:0] a);
      host.xfer({2'b00, a}, 16'h0000, 1, rv);
   endtask : rd

   // one strobed sample of magnitude byte m after the shift
   task automatic samp(logic neg, logic [7:0] m);
      logic [19:0] v;
      v = {1'b0, m, 11'h000};
      if (neg) v = -v;
      @(posedge clk_sys);
      sampleValid <= 1'b1;
      lpfSample <= v;
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : samp

   task automatic hc(logic neg, logic [7:0] m);
      samp(neg, m);
      samp(neg, m);
   endtask : hc

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_regs();
      rd(ADDR_FLAGS);
      chk("flags", 16'h0040, rv);
      wr(ADDR_MASK, 16'h00FF);
      @(negedge clk_sys);
      chk("irqN", 16'h0001, irqN);
      rd(ADDR_MASK);
      chk("mask", 16'h00BF, rv);
      rd(ADDR_FLAGS_RC);
      chk("flags rc", 16'h0040, rv);
      rd(ADDR_FLAGS);
      chk("flags", 16'h0000, rv);
   endtask : t_regs

   // equal-to-threshold half cycles must not count, then two low ones
   task automatic t_dip();
      wr(ADDR_DIPLVL, 16'h0010);
      wr(ADDR_DIPCYC, 16'h0002);
      wr(ADDR_MASK, 16'h0002);
      hc(0, 8'h20);
      hc(1, 8'h10);
      hc(0, 8'h10);
      hc(1, 8'h10);
      @(negedge clk_sys);
      chk("dipAlarmN", 16'h0001, dipAlarmN);
      hc(0, 8'h08);
      hc(1, 8'h08);
      @(negedge clk_sys);
      chk("dipAlarmN", 16'h0001, dipAlarmN);
      chk("zeroCross", 16'h0000, zeroCross);
      hc(0, 8'h08);
      @(negedge clk_sys);
      chk("dipAlarmN", 16'h0000, dipAlarmN);
      chk("zeroCross", 16'h0001, zeroCross);
      chk("irqN", 16'h0000, irqN);
      chk("irqSeen", 16'h0001, irqSeen);
      hc(1, 8'h20);
      @(negedge clk_sys);
      chk("dipAlarmN", 16'h0001, dipAlarmN);
   endtask : t_dip

   // temperature completes inside the data byte of a clearing read
   task automatic t_status();
      wr(ADDR_MODE, 16'h0020);
      wr(ADDR_MASK, 16'h0022);
      fork
         host.xfer({2'b00, ADDR_FLAGS_RC}, 16'h0000, 1, rv);
         begin
            repeat (72) @(posedge clk_sys);
            samp(0, 8'h20);
            @(negedge clk_sys);
            chk("tempSelect", 16'h0001, tempSelect);
            repeat (25) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("irqN", 16'h0001, irqN);
            chk("doutEn", 16'h0001, doutEn);
         end
      join
      chk("flags rc", 16'h0002, rv);
      @(negedge clk_sys);
      chk("irqN", 16'h0000, irqN);
      chk("irqSeen", 16'h0001, irqSeen);
      chk("doutEn", 16'h0000, doutEn);
      chk("tempSelect", 16'h0000, tempSelect);
      rd(ADDR_FLAGS_RC);
      chk("flags rc", 16'h0020, rv);
      @(negedge clk_sys);
      chk("irqN", 16'h0001, irqN);
      rd(ADDR_TEMP);
      chk("temp", 16'h00E7, rv);
      rd(ADDR_MODE);
      chk("mode", 16'h0000, rv);
   endtask : t_status

   task automatic t_supply();
      @(posedge clk_sys);
      supplyLow <= 1'b1;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("energyEnable", 16'h0000, energyEnable);
      @(posedge clk_sys);
      supplyLow <= 1'b0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("energyEnable", 16'h0001, energyEnable);
      rd(ADDR_FLAGS);
      chk("flags", 16'h0040, rv);
      rd(ADDR_FLAGS_RC);
   endtask : t_supply

   // short timeout with pin disabled and nothing enabled
   task automatic t_timeout();
      wr(ADDR_MASK, 16'h0000);
      wr(ADDR_MODE, 16'h0008);
      wr(ADDR_ZXTO, 16'h0002);
      samp(1, 8'h20);
      repeat (400) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("dipAlarmN", 16'h0001, dipAlarmN);
      chk("irqN", 16'h0001, irqN);
      rd(ADDR_FLAGS);
      chk("flags", 16'h0002, rv);
   endtask : t_timeout

   // main sequence
   initial begin
      srst = 1'b1;
      sampleValid = 1'b0;
      lpfSample = 20'h00000;
      supplyLow = 1'b0;
      tempCode = 8'hE7;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("dipAlarmN", 16'h0000, dipAlarmN);
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      t_regs();
      t_dip();
      t_status();
      t_supply();
      t_timeout();
      report_and_stop();
   end
endmodule : test_sag_detect_and_event_irq
